// [sdt_top.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module sdt_top
  import sdt_pkg::*;
#(
  parameter longint SEC_CYCLES   = CYC_SEC,
  parameter longint PULSE_CYCLES = CYC_PULSE,
  parameter longint STEP_CYCLES  = CYC_STEP,
  parameter longint RXIDL_CYCLES = CYC_RXIDL
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Charger side.
  input  wire logic [11:0] panel_cv,
  input  wire logic        load_on,
  input  wire logic        timer_on,
  input  wire logic        energy_tick,
  input  wire logic        ser_tx,
  // Pins.
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             light_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave.

  logic [31:0] ctrl_ff, nthr_ff, dthr_ff, delay_ff, dim_ff, shift_ff;
  logic [31:0] status;
  logic [7:0]  aw_ff;
  logic [31:0] wd_ff;
  logic [3:0]  ws_ff;
  logic        awh_ff, wh_ff;
  logic        do_wr;
  logic [31:0] wmask;
  logic [10:0] tod_ff;
  logic        tod_wr;

  assign awready = !awh_ff;
  assign wready  = !wh_ff;
  assign arready = !rvalid;
  assign do_wr   = awh_ff && wh_ff && !bvalid;
  assign wmask   = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};
  assign tod_wr  = do_wr && aw_ff[7:2] == OFS_TOD[7:2];

  // Address and data are held until both have arrived.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_ff <= 1'b0;
      wh_ff  <= 1'b0;
      aw_ff  <= 8'h00;
      wd_ff  <= RST_ZERO;
      ws_ff  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awh_ff <= 1'b1;
        aw_ff  <= awaddr;
      end else if (do_wr) begin
        awh_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        wh_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end else if (do_wr) begin
        wh_ff <= 1'b0;
      end
    end
  end

  // Register writes with byte strobes; unmapped offsets answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ctrl_ff, nthr_ff, dthr_ff} <= {3{RST_ZERO}};
      {delay_ff, dim_ff, shift_ff} <= {3{RST_ZERO}};
      bvalid <= 1'b0;
      bresp  <= 2'b00;
    end else begin
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= 2'b00;
        unique case (aw_ff[7:2])
          OFS_CTRL[7:2]:  ctrl_ff  <= (ctrl_ff & ~wmask) | (wd_ff & wmask);
          OFS_NTHR[7:2]:  nthr_ff  <= (nthr_ff & ~wmask) | (wd_ff & wmask);
          OFS_DTHR[7:2]:  dthr_ff  <= (dthr_ff & ~wmask) | (wd_ff & wmask);
          OFS_DELAY[7:2]: delay_ff <= (delay_ff & ~wmask) | (wd_ff & wmask);
          OFS_DIM[7:2]:   dim_ff   <= (dim_ff & ~wmask) | (wd_ff & wmask);
          OFS_SHIFT[7:2]: shift_ff <= (shift_ff & ~wmask) | (wd_ff & wmask);
          OFS_TOD[7:2], OFS_STATUS[7:2]: bresp <= 2'b00;
          default:        bresp    <= 2'b10;
        endcase
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= RST_ZERO;
      rresp  <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= 2'b00;
      unique case (araddr[7:2])
        OFS_CTRL[7:2]:   rdata <= {28'h0, ctrl_ff[3:0]};
        OFS_NTHR[7:2]:   rdata <= {20'h0, nthr_ff[11:0]};
        OFS_DTHR[7:2]:   rdata <= {20'h0, dthr_ff[11:0]};
        OFS_DELAY[7:2]:  rdata <= {18'h0, delay_ff[13:8], 2'b00, delay_ff[5:0]};
        OFS_DIM[7:2]:    rdata <= {17'h0, dim_ff[14:8], 1'b0, dim_ff[6:0]};
        OFS_SHIFT[7:2]:  rdata <= {20'h0, shift_ff[11:0]};
        OFS_TOD[7:2]:    rdata <= {21'h0, tod_ff};
        OFS_STATUS[7:2]: rdata <= status;
        default: begin
          rdata <= RST_ZERO;
          rresp <= 2'b10;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second and minute ticks, time of day.

  logic [31:0] sec_cnt_ff;
  logic [5:0]  min_cnt_ff;
  logic        sec_tick, min_tick;

  assign sec_tick = sec_cnt_ff == 32'(SEC_CYCLES - 1);
  assign min_tick = sec_tick && min_cnt_ff == SEC_PER_MIN - 6'h01;

  // Free-running prescalers; software may set the minute of day.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_ff <= RST_ZERO;
      min_cnt_ff <= 6'h00;
      tod_ff     <= 11'h000;
    end else begin
      sec_cnt_ff <= sec_tick ? RST_ZERO : sec_cnt_ff + 32'h1;
      if (sec_tick) begin
        min_cnt_ff <= min_tick ? 6'h00 : min_cnt_ff + 6'h01;
      end
      if (tod_wr) begin
        tod_ff <= wd_ff[10:0] < DAY_MIN ? wd_ff[10:0] : 11'h000;
      end else if (min_tick) begin
        tod_ff <= tod_ff == DAY_MIN - 11'h001 ? 11'h000 : tod_ff + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Night and day detection with qualification delay.

  logic [11:0] n_lvl, d_lvl, pv_s1_ff, pv_s2_ff, pv_d_ff, pv_ff;
  logic [5:0]  n_dly, d_dly, dly_sel;
  logic [11:0] qual_ff;
  logic        night_ff, flip_cond;

  // [RQ3] Built-in levels
  // [RQ2] Minimum level clamp
  assign n_lvl = nthr_ff[11:0] == 12'h0 ? PV_MIN_CV :
                 nthr_ff[11:0] < PV_MIN_CV ? PV_MIN_CV : nthr_ff[11:0];
  assign d_lvl = dthr_ff[11:0] == 12'h0 ? PV_RISE_CV :
                 dthr_ff[11:0] < PV_MIN_CV ? PV_MIN_CV : dthr_ff[11:0];
  assign n_dly = delay_ff[5:0] > DELAY_MAX ? DELAY_MAX : delay_ff[5:0];
  assign d_dly = delay_ff[13:8] > DELAY_MAX ? DELAY_MAX : delay_ff[13:8];
  assign dly_sel   = night_ff ? d_dly : n_dly;
  assign flip_cond = night_ff ? pv_ff > d_lvl : pv_ff < n_lvl;

  // Panel voltage comes from another domain; a word caught mid-change could
  // tear, so a value is used only once two synchronised samples agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pv_s1_ff <= 12'hfff;
      pv_s2_ff <= 12'hfff;
      pv_d_ff  <= 12'hfff;
      pv_ff    <= 12'hfff;
    end else begin
      pv_s1_ff <= panel_cv;
      pv_s2_ff <= pv_s1_ff;
      pv_d_ff  <= pv_s2_ff;
      if (pv_s2_ff == pv_d_ff) begin
        pv_ff <= pv_s2_ff;
      end
    end
  end

  // [RQ4] Persistence delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      night_ff <= 1'b0;
      qual_ff  <= 12'h000;
    end else if (!flip_cond) begin
      qual_ff <= 12'h000;
    end else if (qual_ff >= {6'h00, dly_sel} * {6'h00, SEC_PER_MIN}) begin
      night_ff <= !night_ff;
      qual_ff  <= 12'h000;
    end else if (sec_tick) begin
      qual_ff <= qual_ff + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Solar midnight estimate and synchronisation.

  logic        night_d_ff, sunset, sunrise, synced;
  logic [10:0] set_tod_ff, ngt_cnt_ff, ngt_len_ff, rise_gap_ff;
  logic [1:0]  sync_ff;
  logic [11:0] mid_raw, mid_sh;
  logic [10:0] midnight;

  assign sunset  = night_ff && !night_d_ff;
  assign sunrise = !night_ff && night_d_ff;
  assign synced  = sync_ff == SYNC_CYCLES;

  // Sunset time, night length and sunrise spacing are measured in minutes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      night_d_ff  <= 1'b0;
      set_tod_ff  <= 11'h000;
      ngt_cnt_ff  <= 11'h000;
      ngt_len_ff  <= UNSYNC_NGT;
      rise_gap_ff <= 11'h000;
      sync_ff     <= 2'b00;
    end else begin
      night_d_ff <= night_ff;
      if (sunset) begin
        set_tod_ff <= tod_ff;
        ngt_cnt_ff <= 11'h000;
      end else if (min_tick && night_ff && ngt_cnt_ff != 11'h7ff) begin
        ngt_cnt_ff <= ngt_cnt_ff + 11'h001;
      end
      if (sunrise) begin
        ngt_len_ff  <= ngt_cnt_ff;
        rise_gap_ff <= 11'h000;
        if (rise_gap_ff >= SYNC_LO && rise_gap_ff <= SYNC_HI) begin
          sync_ff <= synced ? sync_ff : sync_ff + 2'b01;
        end else begin
          sync_ff <= 2'b00;
        end
      end else if (min_tick && rise_gap_ff != 11'h7ff) begin
        rise_gap_ff <= rise_gap_ff + 11'h001;
      end
    end
  end

  // [RQ16] Fixed 6 h midnight
  // [RQ8] Sunset plus half night
  assign mid_raw = {1'b0, set_tod_ff} + {1'b0, synced ? ngt_len_ff >> 1 : UNSYNC_MID};
  // [RQ7] Midnight shift
  assign mid_sh  = (mid_raw >= {1'b0, DAY_MIN} ? mid_raw - {1'b0, DAY_MIN} : mid_raw)
                   + shift_ff[11:0];
  assign midnight = mid_sh[11] ? 11'(mid_sh + {1'b0, DAY_MIN}) :
                    mid_sh >= {1'b0, DAY_MIN} ? 11'(mid_sh - {1'b0, DAY_MIN}) :
                    mid_sh[10:0];

  ////////////////////////////////////////////////////////////////////////////
  // Gradual dimming.

  logic [6:0] tgt, spd, tgt_d_ff, lvl_ff, step_sec_ff;

  // [RQ18] Whole percent target
  assign tgt = dim_ff[6:0] > DIM_FULL ? DIM_FULL : dim_ff[6:0];
  assign spd = dim_ff[14:8] > SPEED_MAX ? SPEED_MAX : dim_ff[14:8];

  // [RQ5] One step per interval
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_ff      <= 7'h00;
      tgt_d_ff    <= 7'h00;
      step_sec_ff <= 7'h00;
    end else begin
      tgt_d_ff <= tgt;
      if (spd == 7'h00) begin
        // [RQ6] Immediate level
        lvl_ff      <= tgt;
        step_sec_ff <= 7'h00;
      end else if (tgt != tgt_d_ff || tgt == lvl_ff) begin
        // [RQ19] Restart or hold
        step_sec_ff <= 7'h00;
      end else if (sec_tick) begin
        if (step_sec_ff + 7'h01 >= spd) begin
          step_sec_ff <= 7'h00;
          lvl_ff      <= tgt > lvl_ff ? lvl_ff + 7'h01 : lvl_ff - 7'h01;
        end else begin
          step_sec_ff <= step_sec_ff + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM, energy pulse and receive activity.

  logic [31:0] pstep_ff, epul_ff, rxidl_ff;
  logic [6:0]  ppos_ff;
  logic        rx_s1_ff, rx_ff, pwm_hi, rx_act;

  // [RQ14] Fixed 160 Hz frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pstep_ff <= RST_ZERO;
      ppos_ff  <= 7'h00;
    end else if (pstep_ff == 32'(STEP_CYCLES - 1)) begin
      pstep_ff <= RST_ZERO;
      ppos_ff  <= ppos_ff == DIM_FULL - 7'h01 ? 7'h00 : ppos_ff + 7'h01;
    end else begin
      pstep_ff <= pstep_ff + 32'h1;
    end
  end

  // [RQ11] Duty equals level
  assign pwm_hi = ppos_ff < lvl_ff;

  // [RQ10] Low pulse per tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      epul_ff <= RST_ZERO;
    end else if (energy_tick) begin
      epul_ff <= 32'(PULSE_CYCLES);
    end else if (epul_ff != RST_ZERO) begin
      epul_ff <= epul_ff - 32'h1;
    end
  end

  // [RQ15] Receive activity window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_ff <= 1'b1;
      rx_ff    <= 1'b1;
      rxidl_ff <= RST_ZERO;
    end else begin
      rx_s1_ff <= rx_pin;
      rx_ff    <= rx_s1_ff;
      rxidl_ff <= !rx_ff ? 32'(RXIDL_CYCLES) :
                  rxidl_ff != RST_ZERO ? rxidl_ff - 32'h1 : RST_ZERO;
    end
  end
  assign rx_act = rxidl_ff != RST_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Light output and transmit pin selection.

  logic     tx_nxt;
  sdt_txf_t txf;

  assign txf = sdt_txf_t'(ctrl_ff[2:0]);

  // [RQ17] Load AND timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      light_on <= 1'b0;
    end else begin
      light_on <= ctrl_ff[POS_SLEN] ? load_on && timer_on : load_on;
    end
  end

  // [RQ9] Pin function select
  always_comb begin
    tx_nxt = ser_tx;
    if (!rx_act) begin
      unique case (txf)
        TX_SERIAL: tx_nxt = ser_tx;
        TX_ENERGY: tx_nxt = epul_ff == RST_ZERO;
        TX_PWM:    tx_nxt = pwm_hi;
        // [RQ12] Complement duty
        TX_PWMINV: tx_nxt = !pwm_hi;
        // [RQ13] Load state copy
        TX_VLOAD:  tx_nxt = light_on;
        default:   tx_nxt = ser_tx;
      endcase
    end
  end

  // Transmit pin is registered; idle level is high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= tx_nxt;
    end
  end

  assign status = {11'h0, midnight, lvl_ff, rx_act, synced, night_ff};

endmodule : sdt_top

// [sdt_pkg.sv]
// Notes on behaviour
// [RQ1] Software keeps day threshold 0.5 V above night.
// [RQ2] Thresholds below 11.4 V are raised to it.
// [RQ3] Zero threshold selects 11.4 V / 11.9 V.
// [RQ4] Night/day must persist 0..60 min delay.
// [RQ5] Ramp one percent per programmed seconds, 0..99.
// [RQ6] Speed zero applies new dim level at once.
// [RQ7] Signed minute shift moves midnight anchor only.
// [RQ8] Midnight is sunset plus half night, mod 1440.
// [RQ9] Selector picks five transmit functions, serial default.
// [RQ10] Energy pulse: pin low 250 ms per 0.01 kWh.
// [RQ11] Normal dimming duty equals dim level.
// [RQ12] Inverted dimming duty is complement of level.
// [RQ13] Virtual load mode copies the load state.
// [RQ14] Dimming PWM runs at fixed 160 Hz.
// [RQ15] Incoming serial data restores serial while receiving.
// [RQ16] Unsynchronised: midnight 6 h, night 12 h.
// [RQ17] Streetlight enabled: light is load AND timer.
// [RQ18] Dim level and duty in whole percent steps.
// [RQ19] Equal target holds; target change restarts interval.
package sdt_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_NTHR   = 8'h04;
  localparam logic [7:0] OFS_DTHR   = 8'h08;
  localparam logic [7:0] OFS_DELAY  = 8'h0c;
  localparam logic [7:0] OFS_DIM    = 8'h10;
  localparam logic [7:0] OFS_SHIFT  = 8'h14;
  localparam logic [7:0] OFS_TOD    = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Field positions.
  localparam int POS_SLEN  = 3;
  localparam int POS_DDLY  = 8;
  localparam int POS_SPEED = 8;

  // Panel levels in units of 10 mV.
  localparam logic [11:0] PV_MIN_CV  = 12'h474; // 11.40 V
  localparam logic [11:0] PV_RISE_CV = 12'h4a6; // 11.90 V

  // Limits and day length.
  localparam logic [5:0]  DELAY_MAX   = 6'h3c;  // 60 minutes
  localparam logic [6:0]  SPEED_MAX   = 7'h63;  // 99 seconds
  localparam logic [6:0]  DIM_FULL    = 7'h64;  // 100 percent
  localparam logic [10:0] DAY_MIN     = 11'h5a0; // 1440 minutes
  localparam logic [10:0] UNSYNC_MID  = 11'h168; // 6 hours
  localparam logic [10:0] UNSYNC_NGT  = 11'h2d0; // 12 hours
  localparam logic [10:0] SYNC_LO     = 11'h564; // 23 hours
  localparam logic [10:0] SYNC_HI     = 11'h5dc; // 25 hours
  localparam logic [1:0]  SYNC_CYCLES = 2'h3;
  localparam logic [5:0]  SEC_PER_MIN = 6'h3c;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Timing.
  localparam longint CLK_HZ    = 250_000_000;
  localparam longint PULSE_MS  = 250;
  localparam longint PWM_HZ    = 160;
  localparam longint RX_IDLE_US = 1000;
  localparam longint CYC_SEC   = CLK_HZ;
  localparam longint CYC_PULSE = CLK_HZ / 1000 * PULSE_MS;
  localparam longint CYC_STEP  = CLK_HZ / (PWM_HZ * 100);
  localparam longint CYC_RXIDL = CLK_HZ / 1_000_000 * RX_IDLE_US;

  // Transmit pin functions.
  typedef enum logic [2:0] {
    TX_SERIAL = 3'b000,
    TX_ENERGY = 3'b001,
    TX_PWM    = 3'b010,
    TX_PWMINV = 3'b011,
    TX_VLOAD  = 3'b100
  } sdt_txf_t;

endpackage : sdt_pkg

// [sdt_top_checker.sv]
`timescale 1ns/10ps
module sdt_top_checker
  import sdt_pkg::*;
(
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Charger side and pins.
  input wire logic        load_on,
  input wire logic        timer_on,
  input wire logic        ser_tx,
  input wire logic        tx_pin,
  input wire logic        light_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] adr_ff;
  logic [3:0] wd_ff, ctl_ff, ctl_q_ff;
  logic       bv_ff, lq1_ff, lq2_ff;
  logic       exp_light;

  ////////////////////////////////////////
  // Mirror of the control bits; it lags the real register by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= 4'h0;
      bv_ff  <= 1'b0;
    end else begin
      bv_ff <= bvalid;
      if (awvalid && awready) adr_ff <= awaddr;
      if (wvalid && wready) wd_ff <= wdata[3:0];
      if (bvalid && !bv_ff && adr_ff[7:2] == 6'h0) ctl_ff <= wd_ff;
    end
  end

  // Short history used to wait out mode and light changes.
  always_ff @(posedge aclk) begin
    ctl_q_ff <= ctl_ff;
    lq1_ff   <= light_on;
    lq2_ff   <= lq1_ff;
  end

  // Light state expected from the streetlight gate.
  assign exp_light = ctl_ff[3] ? (load_on & timer_on) : load_on;

  ////////////////////////////////////////
  a_wr_resp: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !wready ##1 bvalid) else $error("write response late");
  a_bresp_hold: assert property (bvalid |=> $past(bready) ? !bvalid : bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid |=> $past(rready) ? !rvalid : rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ar_block: assert property (rvalid |-> !arready) else $error("read taken while busy");
  a_rd_resp: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  a_unmap_err: assert property (arvalid && arready && araddr[7:5] != 3'h0
    |=> rresp == 2'b10 && rdata == 32'h0) else $error("unmapped read not refused");
  a_light_and: assert property (
    $past(aresetn) && ctl_ff == ctl_q_ff |-> light_on == $past(exp_light))
    else $error("light state wrong");
  a_vload_copy: assert property (
    ctl_ff[2:0] == TX_VLOAD && ctl_ff == ctl_q_ff && light_on == lq1_ff && lq1_ff == lq2_ff
    |-> tx_pin == light_on) else $error("pin does not copy load");
  a_serial_pass: assert property (
    $past(aresetn) && ctl_ff[2:0] == TX_SERIAL && ctl_ff == ctl_q_ff
    |-> tx_pin == $past(ser_tx)) else $error("serial data not passed");

  c_slverr: cover property (bvalid && bresp == 2'b10);
  c_vload: cover property (ctl_ff[2:0] == TX_VLOAD && tx_pin);
  c_rderr: cover property (rvalid && rresp == 2'b10);
endmodule : sdt_top_checker

bind sdt_top sdt_top_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .load_on(load_on), .timer_on(timer_on),
  .ser_tx(ser_tx), .tx_pin(tx_pin), .light_on(light_on)
);

// [sdt_led_meter.sv]
`timescale 1ns/10ps
module sdt_led_meter
  import sdt_pkg::*;
(
  // Clock.
  input  wire logic        aclk,
  // Dim input side.
  input  wire logic        tx_pin,
  input  wire logic        meas,
  output logic [31:0]      hi_cnt,
  output logic [31:0]      lo_len,
  // Serial host side.
  input  wire logic        send,
  output logic             rx_pin
);
  logic [31:0] run_ff = 32'h0;
  logic [4:0]  frm_ff = 5'h0;

  // Duty meter counts high samples while the window is open.
  always_ff @(posedge aclk) begin
    hi_cnt <= meas ? hi_cnt + 32'(tx_pin) : 32'h0;
  end

  // Keeps the length of the last completed low pulse.
  always_ff @(posedge aclk) begin
    run_ff <= tx_pin ? 32'h0 : run_ff + 32'h1;
    if (tx_pin && run_ff != 32'h0) lo_len <= run_ff;
  end

  // A host frame toggles the line, then the pull-up holds it high.
  always_ff @(posedge aclk) begin
    if (send) frm_ff <= 5'h10;
    else if (frm_ff != 5'h0) frm_ff <= frm_ff - 5'h1;
  end
  assign rx_pin = (frm_ff == 5'h0) | frm_ff[1];
endmodule : sdt_led_meter

// [tb_streetlight_dimming_tx_output.sv]
`timescale 1ns/10ps
module tb_streetlight_dimming_tx_output
  import sdt_pkg::*;
  ;
  localparam longint SECC = 20;
  localparam longint PULC = 10;
  localparam longint STPC = 2;
  localparam longint RXIC = 30;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, load_on, timer_on, energy_tick;
  logic        ser_tx, rx_pin, tx_pin, light_on, meas, send;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data, hi_cnt, lo_len;
  logic [1:0]  bresp, rresp, resp;
  logic [11:0] panel_cv;
  logic [11:0] pvs [6] = '{12'h473, 12'h4a6, 12'h4a7, 12'h474, 12'h473, 12'h4b1};
  logic [5:0]  nts = 6'h33;
  int          lvs [4] = '{0, 100, 37, 0};
  int          errors = 0, checks = 0, seed = 42, cyc = 0, k, m, lv;

  sdt_top #(.SEC_CYCLES(SECC), .PULSE_CYCLES(PULC), .STEP_CYCLES(STPC),
    .RXIDL_CYCLES(RXIC)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .panel_cv(panel_cv), .load_on(load_on), .timer_on(timer_on),
    .energy_tick(energy_tick), .ser_tx(ser_tx), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .light_on(light_on)
  );
  sdt_led_meter u_far (.aclk(aclk), .tx_pin(tx_pin), .meas(meas), .hi_cnt(hi_cnt),
    .lo_len(lo_len), .send(send), .rx_pin(rx_pin));

  ////////////////////////////////////////
  // Free-running clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Cuts a hung run short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write one word; bready stands from the request until bvalid is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read one word; rready stands from the request until rvalid is seen.
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_data = rdata;
    resp    = rresp;
    rready <= 1'b0;
  endtask : rd

  // Expected high samples over one dimming period.
  function automatic logic [31:0] duty(input int md, input int l);
    return 32'(((md == 2) ? l : 100 - l) * STPC);
  endfunction : duty

  ////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {load_on, timer_on, energy_tick, meas, send} = '0;
    {awaddr, araddr, wdata} = '0;
    panel_cv = 12'hfff;
    ser_tx = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 7; k++) begin
      rd(8'(k * 4));
      chk(rd_data, 32'h0);
    end
    rd(8'h20);
    chk(rd_data, 32'h0);
    chk(32'(resp), 32'h2);
    wr(8'h20, 32'h1);
    chk(32'(resp), 32'h2);
    for (k = 0; k < 16; k++) begin
      @(posedge aclk);
      ser_tx <= 1'($random(seed));
      @(posedge aclk);
      @(negedge aclk);
      chk(tx_pin, ser_tx);
    end
    for (m = 0; m < 2; m++) begin
      wr(OFS_CTRL, 32'(m * 8 + 4));
      for (k = 0; k < 8; k++) begin
        @(posedge aclk);
        {load_on, timer_on} <= 2'($random(seed));
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        lv = m ? load_on & timer_on : load_on;
        chk(light_on, lv);
        chk(tx_pin, lv);
      end
    end
    wr(OFS_CTRL, 32'h1);
    @(negedge aclk);
    chk(tx_pin, 32'h1);
    @(posedge aclk);
    energy_tick <= 1'b1;
    @(posedge aclk);
    energy_tick <= 1'b0;
    repeat (PULC + 6) @(posedge aclk);
    @(negedge aclk);
    chk(lo_len, 32'(PULC));
    for (m = 2; m < 4; m++) begin
      wr(OFS_CTRL, 32'(m));
      for (k = 0; k < 4; k++) begin
        lv = (k == 3) ? ($random(seed) & 127) : lvs[k];
        wr(OFS_DIM, 32'(lv));
        lv = (lv > 100) ? 100 : lv;
        repeat (4) @(posedge aclk);
        meas <= 1'b1;
        repeat (100 * STPC) @(posedge aclk);
        meas <= 1'b0;
        @(negedge aclk);
        chk(hi_cnt, duty(m, lv));
        rd(OFS_STATUS);
        chk(32'(rd_data[9:3]), 32'(lv));
      end
    end
    wr(OFS_DIM, 32'h0);
    wr(OFS_DIM, 32'h103);
    rd(OFS_STATUS);
    chk(32'(rd_data[9:3] > 7'h1), 32'h0);
    repeat (5 * SECC) @(posedge aclk);
    rd(OFS_STATUS);
    chk(32'(rd_data[9:3]), 32'h3);
    repeat (3 * SECC) @(posedge aclk);
    rd(OFS_STATUS);
    chk(32'(rd_data[9:3]), 32'h3);
    // panel thresholds; first sunset near minute 1200.
    wr(OFS_TOD, 32'h4b0);
    for (k = 0; k < 6; k++) begin
      if (k == 3) begin
        wr(OFS_NTHR, 32'h3e8);
        wr(OFS_DTHR, 32'h4b0);
        wr(OFS_DELAY, 32'h100);
      end
      panel_cv <= pvs[k];
      repeat (8) @(posedge aclk);
      rd(OFS_STATUS);
      chk(rd_data[0], nts[k]);
      if (k == 1) begin
        // unsynchronised midnight, sunset plus 6 h
        chk(32'(rd_data[20:10] - 11'h078 < 11'h002), 32'h1);
        wr(OFS_SHIFT, 32'hf38);
        rd(OFS_STATUS);
        chk(32'(rd_data[20:10] - 11'h550 < 11'h002), 32'h1);
      end
    end
    repeat (61 * SECC) @(posedge aclk);
    rd(OFS_STATUS);
    chk(rd_data[0], 32'h0);
    wr(OFS_CTRL, 32'h1);
    ser_tx <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(tx_pin, 32'h1);
    @(posedge aclk);
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk(tx_pin, 32'h0);
    repeat (24 + RXIC) @(posedge aclk);
    @(negedge aclk);
    chk(tx_pin, 32'h1);
    report_and_stop();
  end
endmodule : tb_streetlight_dimming_tx_output
